// >>> hw/pdl_consts.svh
`ifndef PDL_CONSTS_SVH
`define PDL_CONSTS_SVH
// ==========================================================
// Register offsets (byte addresses, one word each)
`define PDL_REG_CTRL 8'h00
`define PDL_REG_FBDIV 8'h04
`define PDL_REG_PLL2 8'h08
`define PDL_REG_STAT 8'h0c
`define PDL_REG_MASK 8'h10
`define PDL_REG_LIVE 8'h14
`define PDL_REG_CHAN0 8'h20
`define PDL_REG_CHAN4 8'h30
// ==========================================================
// Control register fields
`define PDL_CTRL_FBSEL 0
`define PDL_CTRL_BYPASS 1
`define PDL_CTRL_DBL 2
`define PDL_CTRL_PD 3
`define PDL_CTRL_BLOCK 4
`define PDL_CTRL_REVALIDATION_COUNT_LSB 8
// ==========================================================
// Reset values (the control register resets to 32'h00000304; the CTRL value here is not used)
`define PDL_CTRL_RST 32'h0000_0308
`define PDL_MV0_RST 12'h001
`define PDL_MV1_RST 9'h008
`define PDL_PF_RST 6'h01
`define PDL_MF_RST 9'h008
`define PDL_NX_RST 8'h01
// ==========================================================
// Divider limits and monitor timing
`define PDL_NX_MIN 8'h01
`define PDL_NX_MAX 8'ha0
`define PDL_MISS_EDGES 2'h3
`define PDL_VCO_KHZ 1966080
`endif

// >>> hw/pdl_pkg.sv
package pdl_pkg;
	typedef struct packed {
		logic [7:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} pdl_bus_req_t;
	typedef struct packed {
		logic feedback_path_select;
		logic first_stage_bypass;
		logic doubler_enable;
		logic loss_ref_divider_powerdown;
		logic loss_flag_block;
		logic [7:0] revalidation_count;
		logic [11:0] primary_feedback_divider;
		logic [8:0] loss_reference_divider;
		logic [5:0] second_stage_predivider;
		logic [8:0] second_stage_feedback_divider;
	} pdl_cfg_t;
	typedef enum logic [1:0] {
		PDL_MON_VALID = 2'b01,
		PDL_MON_LOST = 2'b10
	} pdl_mon_state_t;
endpackage : pdl_pkg

// >>> hw/pdl_divider_monitor.sv
`timescale 1ns/10ps
`include "pdl_consts.svh"
module pdl_divider_monitor #(
	parameter int NUM_IN = 4,
	parameter int NUM_CH = 5
) (
	// Clock, reset, enable
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic CLK_EN,
	// Avalon-MM slave
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Reference inputs and VCO clock
	input wire logic [NUM_IN-1:0] REF_IN,
	input wire logic [NUM_IN-1:0] REF_DIFF_ZERO,
	input wire logic [NUM_IN-1:0] REF_IS_DIFF,
	input wire logic VCO_CLK_IN,
	// Divider configuration to the analog paths, channel clocks and monitor tick
	output logic [20:0] FIRST_STAGE_FB_RATIO,
	output logic SECOND_STAGE_REF_FROM_BYPASS,
	output logic [5:0] SECOND_STAGE_EFF_PREDIV,
	output logic SECOND_STAGE_DOUBLE,
	output logic [8:0] SECOND_STAGE_FB_DIV,
	output logic [NUM_CH*8-1:0] CHANNEL_DIVIDER,
	output logic [NUM_CH-1:0] CHANNEL_CLK_OUT,
	output logic LOSS_REF_TICK,
	// Status
	output logic [NUM_IN-1:0] INPUT_LOSS_INDICATOR,
	output logic IRQ
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [31:0] readdata;
		logic ack;
		pdl_pkg::pdl_cfg_t cfg;
		logic [NUM_CH-1:0][7:0] nx;
		logic [NUM_CH-1:0][7:0] chcnt;
		logic [NUM_CH-1:0] chout;
		logic [NUM_IN-1:0][2:0] ref_sync;
		logic [2:0] vco_sync;
		logic [8:0] mv1cnt;
		logic tick;
		logic [NUM_IN-1:0][1:0] miss;
		logic [NUM_IN-1:0][7:0] good;
		logic [NUM_IN-1:0] lost;
		logic [NUM_IN-1:0] armed;
		logic [NUM_IN-1:0] stat;
		logic [NUM_IN-1:0] mask;
	} pdl_state_t;

	pdl_state_t r, next_r;
	pdl_pkg::pdl_bus_req_t req;
	logic [NUM_IN-1:0] ref_edge;
	logic [NUM_IN-1:0] zero_loss;
	logic [NUM_IN-1:0] loss_event;
	logic vco_edge;
	logic wr;
	logic rd;
	logic [31:0] ctrl_word;

	assign req = '{address: AVS_ADDRESS, read: AVS_READ, write: AVS_WRITE,
		writedata: AVS_WRITEDATA};
	// Write commits at the edge where waitrequest is seen low
	assign wr = req.write && r.ack;
	assign rd = req.read && !r.ack;

	// ==========================================================
	// Edge detection on synchronised inputs
	always_comb begin
		// An edge counts when the second stage is high and the third is still low
		vco_edge = r.vco_sync[1] && !r.vco_sync[2];
		for (int i = 0; i < NUM_IN; i++) begin
			ref_edge[i] = r.ref_sync[i][1] && !r.ref_sync[i][2];
			zero_loss[i] = REF_IS_DIFF[i] && REF_DIFF_ZERO[i];
		end
	end

	assign ctrl_word = {16'h0000, r.cfg.revalidation_count, 3'h0, r.cfg.loss_flag_block,
		r.cfg.loss_ref_divider_powerdown, r.cfg.doubler_enable,
		r.cfg.first_stage_bypass, r.cfg.feedback_path_select};

	// ==========================================================
	// Next state
	always_comb begin
		next_r = r;
		next_r.ack = (req.read || req.write) && !r.ack;
		loss_event = '0;
		for (int i = 0; i < NUM_IN; i++) begin
			next_r.ref_sync[i] = {r.ref_sync[i][1:0], REF_IN[i]};
		end
		next_r.vco_sync = {r.vco_sync[1:0], VCO_CLK_IN};
		// Loss-reference tick: VCO divided by the loss-ref divider
		next_r.tick = 1'b0;
		if (vco_edge && !r.cfg.loss_ref_divider_powerdown) begin
			if (r.mv1cnt + 9'h001 >= r.cfg.loss_reference_divider) begin
				next_r.mv1cnt = '0;
				next_r.tick = 1'b1;
			end else begin
				next_r.mv1cnt = r.mv1cnt + 9'h001;
			end
		end
		// Channel dividers, clamped to 1..160
		for (int c = 0; c < NUM_CH; c++) begin
			if (vco_edge) begin
				if (r.chcnt[c] + 8'h01 >= r.nx[c]) begin
					next_r.chcnt[c] = '0;
					next_r.chout[c] = 1'b1;
				end else begin
					next_r.chcnt[c] = r.chcnt[c] + 8'h01;
					if (r.chcnt[c] + 8'h01 >= (r.nx[c] >> 1)) begin
						next_r.chout[c] = 1'b0;
					end
				end
			end
		end
		// Input monitors
		for (int i = 0; i < NUM_IN; i++) begin
			if (ref_edge[i] && !zero_loss[i]) begin
				next_r.miss[i] = '0;
			end else if (r.tick && r.miss[i] != `PDL_MISS_EDGES) begin
				next_r.miss[i] = r.miss[i] + 2'h1;
			end
			if (!r.lost[i]) begin
				// Reference faster than input trips here early; slower delays it
				if ((r.tick && r.miss[i] == `PDL_MISS_EDGES - 2'h1 && !ref_edge[i])
					|| zero_loss[i]) begin
					next_r.lost[i] = 1'b1;
					next_r.good[i] = '0;
					loss_event[i] = r.armed[i] && !r.cfg.loss_flag_block;
				end
			end else if (ref_edge[i] && !zero_loss[i]) begin
				if (r.good[i] + 8'h01 >= r.cfg.revalidation_count) begin
					next_r.lost[i] = 1'b0;
				end else begin
					next_r.good[i] = r.good[i] + 8'h01;
				end
			end else if (r.tick && r.miss[i] != '0) begin
				next_r.good[i] = '0;
			end
		end
		// Register writes
		if (wr) begin
			case (req.address)
				`PDL_REG_CTRL: begin
					next_r.cfg.feedback_path_select = req.writedata[`PDL_CTRL_FBSEL];
					next_r.cfg.first_stage_bypass = req.writedata[`PDL_CTRL_BYPASS];
					next_r.cfg.doubler_enable = req.writedata[`PDL_CTRL_DBL];
					next_r.cfg.loss_ref_divider_powerdown = req.writedata[`PDL_CTRL_PD];
					next_r.cfg.loss_flag_block = req.writedata[`PDL_CTRL_BLOCK];
					next_r.cfg.revalidation_count = req.writedata[`PDL_CTRL_REVALIDATION_COUNT_LSB +: 8];
				end
				`PDL_REG_FBDIV: begin
					next_r.cfg.primary_feedback_divider = req.writedata[11:0];
					next_r.cfg.loss_reference_divider = req.writedata[24:16];
				end
				`PDL_REG_PLL2: begin
					next_r.cfg.second_stage_predivider = req.writedata[5:0];
					next_r.cfg.second_stage_feedback_divider = req.writedata[24:16];
				end
				`PDL_REG_STAT: begin
					// Write one to clear; clearing re-arms the input
					for (int i = 0; i < NUM_IN; i++) begin
						if (req.writedata[i]) begin
							next_r.stat[i] = 1'b0;
							next_r.armed[i] = 1'b1;
						end
					end
				end
				`PDL_REG_MASK: begin
					next_r.mask = req.writedata[NUM_IN-1:0];
				end
				default: begin
					for (int c = 0; c < NUM_CH; c++) begin
						if (req.address == `PDL_REG_CHAN0 + 8'(4 * c)) begin
							if (req.writedata[7:0] < `PDL_NX_MIN) begin
								next_r.nx[c] = `PDL_NX_MIN;
							end else if (req.writedata[7:0] > `PDL_NX_MAX) begin
								next_r.nx[c] = `PDL_NX_MAX;
							end else begin
								next_r.nx[c] = req.writedata[7:0];
							end
						end
					end
				end
			endcase
		end
		// Set wins over clear
		for (int i = 0; i < NUM_IN; i++) begin
			if (loss_event[i]) begin
				next_r.stat[i] = 1'b1;
				next_r.armed[i] = 1'b0;
			end
		end
		// Register reads; unmapped reads return zero
		if (rd) begin
			case (req.address)
				`PDL_REG_CTRL: next_r.readdata = ctrl_word;
				`PDL_REG_FBDIV: next_r.readdata = {7'h00, r.cfg.loss_reference_divider,
					4'h0, r.cfg.primary_feedback_divider};
				`PDL_REG_PLL2: next_r.readdata = {7'h00, r.cfg.second_stage_feedback_divider,
					10'h000, r.cfg.second_stage_predivider};
				`PDL_REG_STAT: next_r.readdata = 32'(r.stat);
				`PDL_REG_MASK: next_r.readdata = 32'(r.mask);
				`PDL_REG_LIVE: next_r.readdata = 32'(r.lost);
				default: begin
					next_r.readdata = '0;
					for (int c = 0; c < NUM_CH; c++) begin
						if (req.address == `PDL_REG_CHAN0 + 8'(4 * c)) begin
							next_r.readdata = 32'(r.nx[c]);
						end
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			r <= '0;
			r.cfg.feedback_path_select <= 1'b0;
			r.cfg.doubler_enable <= 1'b1;
			r.cfg.revalidation_count <= 8'h03;
			r.cfg.primary_feedback_divider <= `PDL_MV0_RST;
			r.cfg.loss_reference_divider <= `PDL_MV1_RST;
			r.cfg.second_stage_predivider <= `PDL_PF_RST;
			r.cfg.second_stage_feedback_divider <= `PDL_MF_RST;
			r.nx <= {NUM_CH{`PDL_NX_RST}};
			r.armed <= '1;
		end else if (CLK_EN) begin
			r <= next_r;
		end
	end

	// ==========================================================
	// Outputs
	assign AVS_READDATA = r.readdata;
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !r.ack;
	always_comb begin
		// Select 1 folds the loss-ref divider into the first-stage loop
		if (r.cfg.feedback_path_select) begin
			FIRST_STAGE_FB_RATIO = r.cfg.primary_feedback_divider
				* r.cfg.loss_reference_divider;
		end else begin
			FIRST_STAGE_FB_RATIO = 21'(r.cfg.primary_feedback_divider);
		end
	end
	assign SECOND_STAGE_REF_FROM_BYPASS = r.cfg.first_stage_bypass;
	assign SECOND_STAGE_DOUBLE = r.cfg.doubler_enable;
	assign SECOND_STAGE_EFF_PREDIV = r.cfg.doubler_enable ? 6'h01
		: r.cfg.second_stage_predivider;
	assign SECOND_STAGE_FB_DIV = r.cfg.second_stage_feedback_divider;
	assign CHANNEL_DIVIDER = r.nx;
	assign CHANNEL_CLK_OUT = r.chout;
	assign LOSS_REF_TICK = r.tick;
	assign INPUT_LOSS_INDICATOR = r.lost;
	assign IRQ = |(r.stat & r.mask);
endmodule : pdl_divider_monitor

// >>> tb/pdl_divider_monitor_sva.sv
`timescale 1ns/10ps
module pdl_divider_monitor_sva #(
	parameter int NUM_IN = 4,
	parameter int NUM_CH = 5
) (
	// Clock, reset, enable
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic CLK_EN,
	// Bus handshake
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic AVS_WAITREQUEST,
	// Monitor and dividers
	input wire logic [NUM_IN-1:0] REF_DIFF_ZERO,
	input wire logic [NUM_IN-1:0] REF_IS_DIFF,
	input wire logic [5:0] SECOND_STAGE_EFF_PREDIV,
	input wire logic SECOND_STAGE_DOUBLE,
	input wire logic [NUM_CH*8-1:0] CHANNEL_DIVIDER,
	input wire logic [NUM_CH-1:0] CHANNEL_CLK_OUT,
	input wire logic LOSS_REF_TICK,
	input wire logic [NUM_IN-1:0] INPUT_LOSS_INDICATOR,
	input wire logic IRQ
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	logic [NUM_IN-1:0] dz;
	logic bad_div;
	assign dz = REF_DIFF_ZERO & REF_IS_DIFF;
	always_comb begin
		bad_div = 1'b0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (CHANNEL_DIVIDER[8*i +: 8] == 8'h00 || CHANNEL_DIVIDER[8*i +: 8] > 8'ha0) begin
				bad_div = 1'b1;
			end
		end
	end
	// ==========================================================
	// Assertions
	a_dbl_prediv: assert property (SECOND_STAGE_DOUBLE |-> SECOND_STAGE_EFF_PREDIV == 6'h01)
		else $error("prediv active with doubler");
	a_chan_range: assert property (!bad_div)
		else $error("channel divider out of range");
	a_tick_pulse: assert property (LOSS_REF_TICK && CLK_EN |=> !LOSS_REF_TICK)
		else $error("tick wider than one cycle");
	a_diff_loss: assert property ((dz != '0) && CLK_EN |=> (INPUT_LOSS_INDICATOR & $past(dz)) == $past(dz))
		else $error("zero differential without loss");
	a_loss_on_tick: assert property ((|(INPUT_LOSS_INDICATOR & ~$past(INPUT_LOSS_INDICATOR))) && $past(dz) == '0 |-> LOSS_REF_TICK || $past(LOSS_REF_TICK))
		else $error("loss raised away from a tick");
	a_rst_quiet: assert property (disable iff (1'b0) RST |=> !IRQ && INPUT_LOSS_INDICATOR == '0)
		else $error("status not cleared by reset");
	a_hold_frozen: assert property (!CLK_EN |=> $stable(INPUT_LOSS_INDICATOR) && $stable(CHANNEL_CLK_OUT))
		else $error("state moved while frozen");
	a_wait_ack: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && CLK_EN |=> !AVS_WAITREQUEST)
		else $error("bus answer late");
	a_wait_idle: assert property (!AVS_READ && !AVS_WRITE |-> !AVS_WAITREQUEST)
		else $error("waitrequest without request");
	c_irq: cover property ($rose(IRQ));
	c_loss: cover property ($rose(INPUT_LOSS_INDICATOR[1]));
	c_reval: cover property ($fell(INPUT_LOSS_INDICATOR[1]));
endmodule : pdl_divider_monitor_sva
bind pdl_divider_monitor pdl_divider_monitor_sva #(.NUM_IN(NUM_IN), .NUM_CH(NUM_CH)) sva_inst (
	.CORE_CLK(CORE_CLK), .RST(RST), .CLK_EN(CLK_EN), .AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .REF_DIFF_ZERO(REF_DIFF_ZERO),
	.REF_IS_DIFF(REF_IS_DIFF), .SECOND_STAGE_EFF_PREDIV(SECOND_STAGE_EFF_PREDIV),
	.SECOND_STAGE_DOUBLE(SECOND_STAGE_DOUBLE), .CHANNEL_DIVIDER(CHANNEL_DIVIDER),
	.CHANNEL_CLK_OUT(CHANNEL_CLK_OUT), .LOSS_REF_TICK(LOSS_REF_TICK),
	.INPUT_LOSS_INDICATOR(INPUT_LOSS_INDICATOR), .IRQ(IRQ));

// >>> tb/testbench.sv
`timescale 1ns/10ps
`include "pdl_consts.svh"
module testbench;
	logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, rd = 1'b0, wr = 1'b0, vco = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, q, v, seed = 32'h48;
	logic [3:0] ref_in = 4'h0, dzero = 4'h0, isdiff = 4'h0, act = 4'h0, ind;
	logic [20:0] ratio;
	logic [11:0] m0;
	logic [5:0] eprediv, pf;
	logic [8:0] fbdiv;
	logic [39:0] chdiv;
	logic wait_r, byp, dbl, tick, irq;
	int err_count = 0, n_compared = 0, cyc = 0;
	logic [7:0] corner [5] = '{8'h00, 8'ha0, 8'ha1, 8'hff, 8'h01};
	pdl_divider_monitor pdl_divider_monitor_inst (.CORE_CLK(clk), .RST(rst), .CLK_EN(clk_en),
		.AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_r), .REF_IN(ref_in), .REF_DIFF_ZERO(dzero),
		.REF_IS_DIFF(isdiff), .VCO_CLK_IN(vco), .FIRST_STAGE_FB_RATIO(ratio),
		.SECOND_STAGE_REF_FROM_BYPASS(byp), .SECOND_STAGE_EFF_PREDIV(eprediv),
		.SECOND_STAGE_DOUBLE(dbl), .SECOND_STAGE_FB_DIV(fbdiv), .CHANNEL_DIVIDER(chdiv),
		.CHANNEL_CLK_OUT(), .LOSS_REF_TICK(tick), .INPUT_LOSS_INDICATOR(ind), .IRQ(irq));
	always #5 clk = ~clk;
	// Active inputs toggle every cycle; a slow VCO stand-in feeds the dividers
	always @(posedge clk) begin
		cyc <= cyc + 1;
		ref_in <= ref_in ^ act;
		if (cyc % 4 == 0) begin
			vco <= ~vco;
		end
		if (cyc == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic logic [7:0] clampn(input logic [7:0] x);
		return (x == 8'h00) ? 8'h01 : ((x > 8'ha0) ? 8'ha0 : x);
	endfunction : clampn
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Holds the request until waitrequest is seen low at a rising edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		do begin
			@(posedge clk);
		end while (wait_r !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task wait_ind(input logic [3:0] e);
		for (int t = 0; t < 800 && ind !== e; t++) @(posedge clk);
		chk(ind, e);
	endtask : wait_ind
	task tally_and_finish();
		if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		bus(0, `PDL_REG_FBDIV, 0);
		chk(q, {7'h0, `PDL_MV1_RST, 4'h0, `PDL_MV0_RST});
		chk(fbdiv, `PDL_MF_RST);
		for (int i = 0; i < 5; i++) for (int k = 0; k < 2; k++) begin
			v = k ? {24'h0, corner[i]} : xs();
			bus(1, 8'h20 + 8'(4*i), v);
			bus(0, 8'h20 + 8'(4*i), 0);
			chk(q, {24'h0, clampn(v[7:0])});
			chk(chdiv[8*i +: 8], clampn(v[7:0]));
		end
		repeat (8) begin
			v = xs();
			m0 = {v[11:1], 1'b1};
			pf = {v[21:17], 1'b1};
			bus(1, `PDL_REG_FBDIV, {7'h0, 9'h008, 4'h0, m0});
			bus(1, `PDL_REG_PLL2, {7'h0, 9'h010, 10'h0, pf});
			bus(1, `PDL_REG_CTRL, {16'h0, 8'h03, 5'h0, v[26:24]});
			// Outputs follow the write only after its edge
			@(negedge clk);
			chk(ratio, v[24] ? 21'(m0) * 21'd8 : 21'(m0));
			chk(dbl, v[26]);
			chk(eprediv, v[26] ? 6'h01 : pf);
			chk(byp, v[25]);
			chk(fbdiv, 9'h010);
		end
		act <= 4'hf;
		wait_ind(4'h0);
		bus(1, `PDL_REG_STAT, 32'hf);
		bus(1, `PDL_REG_MASK, 32'h2);
		act <= 4'h1;
		wait_ind(4'he);
		bus(0, `PDL_REG_STAT, 0);
		chk(q, 32'he);
		bus(0, `PDL_REG_LIVE, 0);
		chk(q, 32'he);
		chk(irq, 1'b1);
		bus(1, `PDL_REG_MASK, 32'h0);
		@(negedge clk);
		chk(irq, 1'b0);
		act <= 4'hf;
		wait_ind(4'h0);
		bus(1, `PDL_REG_STAT, 32'he);
		bus(0, `PDL_REG_STAT, 0);
		chk(q, 32'h0);
		bus(1, `PDL_REG_CTRL, {16'h0, 8'h03, 8'h10});
		act <= 4'h1;
		wait_ind(4'he);
		bus(0, `PDL_REG_STAT, 0);
		chk(q, 32'h0);
		isdiff <= 4'h1;
		dzero <= 4'h1;
		wait_ind(4'hf);
		dzero <= 4'h0;
		clk_en <= 1'b0;
		repeat (3) @(posedge clk);
		clk_en <= 1'b1;
		bus(0, 8'h3c, 0);
		chk(q, 32'h0);
		tally_and_finish();
	end
endmodule : testbench
